// file: common/spi_reg_pkg.sv
package spi_reg_pkg;
    localparam int              ADDR_W        = 9;
    localparam logic [8:0]      OFF_CTRL      = 9'h000;
    localparam logic [8:0]      OFF_MODE      = 9'h004;
    localparam logic [8:0]      OFF_RXD       = 9'h008;
    localparam logic [8:0]      OFF_TXD       = 9'h00c;
    localparam logic [8:0]      OFF_STAT      = 9'h010;
    localparam logic [8:0]      OFF_IEN       = 9'h014;
    localparam logic [8:0]      OFF_IDIS      = 9'h018;
    localparam logic [8:0]      OFF_IMASK     = 9'h01c;
    localparam logic [8:0]      OFF_CSC0      = 9'h030;
    localparam logic [8:0]      OFF_CSC1      = 9'h034;
    localparam logic [8:0]      OFF_WPM       = 9'h0e4;
    localparam logic [8:0]      OFF_WPS       = 9'h0e8;
    // Control command bits
    localparam int              CR_EN         = 0;
    localparam int              CR_DIS        = 1;
    localparam int              CR_SOFT_RESET      = 7;
    localparam int              CR_LAST       = 24;
    // Mode bits and fields
    localparam int              MR_MASTER_SELECT       = 0;
    localparam int              MR_PS         = 1;
    localparam int              MR_DEC        = 2;
    localparam int              MR_FAULT_DETECT_OFF    = 4;
    localparam int              MR_WAIT_READ_BEFORE_SEND      = 5;
    localparam int              MR_LLB        = 7;
    localparam int              MR_PCS_LO     = 16;
    localparam int              MR_DLY_LO     = 24;
    localparam logic [31:0]     MR_MASK       = 32'hff0300b7;
    localparam logic [31:0]     MR_RESET      = 32'h00000000;
    // Transmit / receive data fields
    localparam int              TD_PCS_LO     = 16;
    localparam int              TD_LAST       = 24;
    localparam int              RD_PCS_LO     = 16;
    // Status bits
    localparam int              SR_RDRF       = 0;
    localparam int              SR_TDRE       = 1;
    localparam int              SR_MODE_FAULT_FLAG       = 2;
    localparam int              SR_TXEMPTY    = 9;
    localparam int              SR_SPIENS     = 16;
    localparam logic [31:0]     SR_PDC_FLAGS  = 32'h000000f0;
    localparam logic [31:0]     IMR_MASK      = 32'h000007ff;
    localparam int              CSR_HOLD      = 3;
    localparam int              WP_ON         = 0;
    localparam int              WPS_VIOL      = 0;
    localparam int              WPS_SRC_LO    = 8;
    // Timing
    localparam logic [7:0]      MIN_GAP       = 8'h06;
    localparam int              CLK_NS        = 100;
    localparam int              SCK_HALF_NS   = 400;
    localparam logic [7:0]      SCK_HALF_CYC  = 8'(SCK_HALF_NS / CLK_NS);
    localparam logic [3:0]      XFER_BITS     = 4'h8;
    localparam logic [1:0]      CS_NONE       = 2'h3;
endpackage : spi_reg_pkg

// file: common/shift_if.sv
`timescale 1ns/10ps
interface shift_if;
    logic       start;
    logic       clr;
    logic       master;
    logic [7:0] tx_byte;
    logic       sck_i;
    logic       miso_i;
    logic       busy;
    logic       done;
    logic [7:0] rx_byte;
    logic       sck_o;
    logic       mosi_o;
    modport ctrl (output start, clr, master, tx_byte, sck_i, miso_i,
                  input busy, done, rx_byte, sck_o, mosi_o);
    modport eng  (input start, clr, master, tx_byte, sck_i, miso_i,
                  output busy, done, rx_byte, sck_o, mosi_o);
endinterface : shift_if

// file: design/spi_shifter.sv
`timescale 1ns/10ps
module spi_shifter
    import spi_reg_pkg::*;
(
    input wire logic mclk,    // Clock
    input wire logic reset_n, // Async reset
    shift_if.eng     sif      // Engine side
);
    logic [7:0] sh_q;
    logic [7:0] rx_q;
    logic [7:0] div_q;
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       done_q;
    logic       sck_q;
    logic       samp_q;
    logic       prev_q;

    // Master makes its own clock edges, slave follows the sampled one
    wire tick     = busy_q && sif.master && (div_q == SCK_HALF_CYC - 8'h01);
    wire rise_ev  = busy_q && (sif.master ? (tick && !sck_q) : (sif.sck_i && !prev_q));
    wire fall_ev  = busy_q && (sif.master ? (tick && sck_q) : (!sif.sck_i && prev_q));
    wire last_bit = (cnt_q == XFER_BITS - 4'h1);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sck_q  <= 1'b0;
            div_q  <= 8'h00;
            cnt_q  <= 4'h0;
            prev_q <= 1'b0;
        end
        else if (sif.clr)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sck_q  <= 1'b0;
            div_q  <= 8'h00;
            cnt_q  <= 4'h0;
            prev_q <= sif.sck_i;
        end
        else
        begin
            prev_q <= sif.sck_i;
            done_q <= fall_ev && last_bit;
            div_q  <= (sif.start || tick) ? 8'h00 : div_q + 8'h01;
            sck_q  <= sif.start ? 1'b0 : (tick ? !sck_q : sck_q);
            if (sif.start)
            begin
                busy_q <= 1'b1;
                cnt_q  <= 4'h0;
            end
            else if (fall_ev)
            begin
                cnt_q  <= cnt_q + 4'h1;
                busy_q <= !last_bit;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sh_q   <= 8'h00;
            rx_q   <= 8'h00;
            samp_q <= 1'b0;
        end
        else
        begin
            if (rise_ev)
                samp_q <= sif.miso_i;
            if (sif.start)
                sh_q <= sif.tx_byte;
            else if (fall_ev)
                sh_q <= {sh_q[6:0], samp_q};
            if (fall_ev && last_bit)
                rx_q <= {sh_q[6:0], samp_q};
        end
    end

    assign sif.busy    = busy_q;
    assign sif.done    = done_q;
    assign sif.rx_byte = rx_q;
    assign sif.sck_o   = sck_q;
    assign sif.mosi_o  = sh_q[7];
endmodule : spi_shifter

// file: design/spi_register_interface.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
// How it works
// - Writing enable command one turns the controller on; zero does nothing.
// - Disable during a transfer finishes the shift, starts nothing new, releases pins.
// - Enable and disable written together leave the controller disabled.
// - Soft reset clears the serial interface to slave mode; DMA untouched.
// - Control final transfer deasserts select after the pending character shifts.
// - Mode register writes are blocked while write protection is on.
// - Mode bits choose slave/master and fixed/variable peripheral select.
// - Decoder mode: lines carry code; config 0 for selects 0-1, config 1 for 2.
// - Fault detect off bit zero enables mode-fault detection, one disables it.
// - Wait-read bit in master mode starts a transfer only with receive empty.
// - Loopback in master mode feeds serial output back to input.
// - Fixed code: x0 gives 10, 01 gives 01, 11 none; decoder passes code.
// - Select gap lasts programmed clocks, never fewer than six.
// - Received data right-justified, unused bits read zero.
// - Receive code shows select lines in master mode, zero otherwise.
// - Transmit code used only in variable mode, same line encoding.
// - Variable mode word with final bit deasserts select after it.
// - Hold bit keeps select asserted until another peripheral or final.
// - Mode fault in master sets flag until status read and disables.
module spi_register_interface
    import spi_reg_pkg::*;
(
    input  wire logic              mclk,     // 10 MHz clock
    input  wire logic              reset_n,  // Async reset, active low
    input  wire logic [ADDR_W-1:0] addr,     // Register byte address
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic              wr,       // Write strobe
    input  wire logic              rd,       // Read strobe
    output logic      [31:0]       rdata,    // Read data, cycle after rd
    input  wire logic              sck_in,   // Serial clock pin in
    output logic                   sck_out,  // Serial clock pin out
    output logic                   sck_oe,   // Serial clock drive
    input  wire logic              mosi_in,  // Master-out pin in
    output logic                   mosi_out, // Master-out pin out
    output logic                   mosi_oe,  // Master-out drive
    input  wire logic              miso_in,  // Master-in pin in
    output logic                   miso_out, // Master-in pin out
    output logic                   miso_oe,  // Master-in drive
    input  wire logic              cs0_in,   // Select 0 / slave select in
    output logic      [1:0]        cs_out,   // Select lines out
    output logic      [1:0]        cs_oe     // Select lines drive
);
    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_SHIFT, ST_HOLD} seq_type;

    shift_if sif ();
    spi_shifter u_shift (.mclk(mclk), .reset_n(reset_n), .sif(sif));

    seq_type     st_q;
    logic [31:0] mode_q, csc0_q, csc1_q, imr_q, rdata_q;
    logic [15:0] txd_q;
    logic [7:0]  rx_q, gap_q;
    logic [1:0]  txd_code_q, cs_q, rx_code_q;
    logic        txd_last_q, en_q, dis_pend_q, tdre_q, rdrf_q, mode_fault_flag_q;
    logic        last_pend_q, sh_last_q, wp_on_q, viol_q;
    logic [7:0]  viol_src_q;
    logic [3:0]  sync1_q, sync2_q;
    logic [2:0]  own_cs0_q;
    logic        nss_prev_q;

    // Pin synchronisers: sck, mosi, miso, cs0
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
        end
        else
        begin
            sync1_q <= {cs0_in, miso_in, mosi_in, sck_in};
            sync2_q <= sync1_q;
        end
    end
    wire sck_s  = sync2_q[0];
    wire mosi_s = sync2_q[1];
    wire miso_s = sync2_q[2];
    wire nss_s  = sync2_q[3];

    // Address decode; unmatched offsets fall through to zero
    wire wr_ctrl = wr && (addr == OFF_CTRL);
    wire wr_mode = wr && (addr == OFF_MODE);
    wire wr_txd  = wr && (addr == OFF_TXD);
    wire wr_csc0 = wr && (addr == OFF_CSC0);
    wire wr_csc1 = wr && (addr == OFF_CSC1);
    wire wr_wpm  = wr && (addr == OFF_WPM);
    wire rd_rxd  = rd && (addr == OFF_RXD);
    wire rd_stat = rd && (addr == OFF_STAT);
    wire rd_wps  = rd && (addr == OFF_WPS);
    wire cmd_en  = wr_ctrl && wdata[CR_EN];
    wire cmd_dis = wr_ctrl && wdata[CR_DIS];
    wire cmd_rst = wr_ctrl && wdata[CR_SOFT_RESET];
    wire cmd_last = wr_ctrl && wdata[CR_LAST];
    wire prot_wr = (wr_mode || wr_csc0 || wr_csc1) && wp_on_q;

    wire       master  = mode_q[MR_MASTER_SELECT];
    wire       var_sel = mode_q[MR_PS];
    wire       dec     = mode_q[MR_DEC];
    wire [1:0] code    = var_sel ? txd_code_q : mode_q[MR_PCS_LO +: 2];
    wire [1:0] target  = dec ? code : (!code[0] ? 2'h2 : (code[1] ? CS_NONE : 2'h1));
    wire [7:0] dly     = mode_q[MR_DLY_LO +: 8];
    wire [7:0] gap_len = (dly < MIN_GAP) ? MIN_GAP : dly;
    // Config 1 serves select 2 with a decoder, line 1 without
    wire       use_c1  = dec ? (cs_q == 2'h2) : (cs_q == 2'h1);
    wire       hold_b  = use_c1 ? csc1_q[CSR_HOLD] : csc0_q[CSR_HOLD];
    wire       loop_on = master && mode_q[MR_LLB];
    wire       done    = sif.done;
    wire       busy_x  = sif.busy || (st_q == ST_SHIFT);
    wire       fault   = en_q && master && !mode_q[MR_FAULT_DETECT_OFF] && !nss_s && (&own_cs0_q);
    wire       tx_pend = en_q && !tdre_q;
    wire       may_go  = tx_pend && master && !dis_pend_q && !sif.busy
                         && !(mode_q[MR_WAIT_READ_BEFORE_SEND] && rdrf_q);
    wire       end_req = last_pend_q || sh_last_q || dis_pend_q || !hold_b;
    wire       load_m  = may_go && ((st_q == ST_IDLE) || (st_q == ST_HOLD && target == cs_q));
    wire       nss_fall = en_q && !master && !nss_s && nss_prev_q;
    wire       load    = load_m || nss_fall;

    assign sif.start   = load;
    assign sif.clr     = cmd_rst || fault;
    assign sif.master  = master;
    assign sif.tx_byte = txd_q[7:0];
    assign sif.sck_i   = sck_s;
    assign sif.miso_i  = master ? (loop_on ? sif.mosi_o : miso_s) : mosi_s;

    // Enable state and disable-after-transfer
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_q       <= 1'b0;
            dis_pend_q <= 1'b0;
        end
        else if (cmd_rst || fault || (done && dis_pend_q))
        begin
            en_q       <= 1'b0;
            dis_pend_q <= 1'b0;
        end
        else if (cmd_dis)
        begin
            en_q       <= busy_x && en_q;
            dis_pend_q <= busy_x && en_q;
        end
        else if (cmd_en)
            en_q <= 1'b1;
    end

    // Mode, select configs, write protection
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= MR_RESET;
            csc0_q <= 32'h00000000;
            csc1_q <= 32'h00000000;
            imr_q  <= 32'h00000000;
        end
        else if (cmd_rst)
        begin
            mode_q <= MR_RESET;
            csc0_q <= 32'h00000000;
            csc1_q <= 32'h00000000;
            imr_q  <= 32'h00000000;
        end
        else
        begin
            if (wr_mode && !wp_on_q)
                mode_q <= wdata & MR_MASK;
            if (wr_csc0 && !wp_on_q)
                csc0_q <= wdata;
            if (wr_csc1 && !wp_on_q)
                csc1_q <= wdata;
            if (wr && addr == OFF_IEN)
                imr_q <= imr_q | (wdata & IMR_MASK);
            else if (wr && addr == OFF_IDIS)
                imr_q <= imr_q & ~wdata;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wp_on_q    <= 1'b0;
            viol_q     <= 1'b0;
            viol_src_q <= 8'h00;
        end
        else
        begin
            if (wr_wpm)
                wp_on_q <= wdata[WP_ON];
            viol_q <= prot_wr || (viol_q && !rd_wps);
            if (prot_wr)
                viol_src_q <= addr[7:0];
        end
    end

    // Transmit holding register and flags
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txd_q       <= 16'h0000;
            txd_code_q  <= 2'h0;
            txd_last_q  <= 1'b0;
            tdre_q      <= 1'b0;
            last_pend_q <= 1'b0;
            sh_last_q   <= 1'b0;
        end
        else if (cmd_rst)
        begin
            tdre_q      <= 1'b0;
            last_pend_q <= 1'b0;
            sh_last_q   <= 1'b0;
        end
        else
        begin
            if (wr_txd)
            begin
                txd_q      <= wdata[15:0];
                txd_code_q <= wdata[TD_PCS_LO +: 2];
                txd_last_q <= wdata[TD_LAST];
            end
            // New data wins over a load of the old word
            tdre_q <= wr_txd ? 1'b0 : ((load || (cmd_en && !cmd_dis)) ? 1'b1 : (tdre_q && en_q));
            if (load_m)
                sh_last_q <= var_sel && txd_last_q;
            else if (done)
                sh_last_q <= 1'b0;
            last_pend_q <= cmd_last || (last_pend_q && !done);
        end
    end

    // Receive register and status flags
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_q      <= 8'h00;
            rx_code_q <= 2'h0;
            rdrf_q    <= 1'b0;
            mode_fault_flag_q    <= 1'b0;
        end
        else if (cmd_rst)
        begin
            rx_q      <= 8'h00;
            rx_code_q <= 2'h0;
            rdrf_q    <= 1'b0;
            mode_fault_flag_q    <= 1'b0;
        end
        else
        begin
            if (done)
            begin
                rx_q      <= sif.rx_byte;
                rx_code_q <= master ? cs_q : 2'h0;
            end
            rdrf_q <= done || (rdrf_q && !rd_rxd);
            mode_fault_flag_q <= fault || (mode_fault_flag_q && !rd_stat);
        end
    end

    // Select sequencer
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q  <= ST_IDLE;
            cs_q  <= CS_NONE;
            gap_q <= 8'h00;
        end
        else if (cmd_rst || fault)
        begin
            st_q  <= ST_IDLE;
            cs_q  <= CS_NONE;
            gap_q <= 8'h00;
        end
        else
        begin
            gap_q <= (st_q == ST_GAP) ? gap_q + 8'h01 : 8'h00;
            unique case (st_q)
                ST_IDLE:
                    if (load_m)
                    begin
                        cs_q <= target;
                        st_q <= ST_SHIFT;
                    end
                ST_SHIFT:
                    if (done && end_req)
                    begin
                        cs_q <= CS_NONE;
                        st_q <= ST_GAP;
                    end
                    else if (done)
                        st_q <= ST_HOLD;
                ST_HOLD:
                    if (load_m)
                        st_q <= ST_SHIFT;
                    else if (!en_q || dis_pend_q || last_pend_q || !hold_b
                             || (may_go && target != cs_q))
                    begin
                        cs_q <= CS_NONE;
                        st_q <= ST_GAP;
                    end
                ST_GAP:
                    if (gap_q >= gap_len - 8'h02)
                        st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            own_cs0_q  <= 3'h0;
            nss_prev_q <= 1'b1;
        end
        else
        begin
            own_cs0_q  <= {own_cs0_q[1:0], cs_q[0]};
            nss_prev_q <= nss_s;
        end
    end

    // Register readback
    logic [31:0] stat_word;
    always_comb
    begin
        stat_word             = SR_PDC_FLAGS;
        stat_word[SR_RDRF]    = rdrf_q;
        stat_word[SR_TDRE]    = tdre_q;
        stat_word[SR_MODE_FAULT_FLAG]    = mode_fault_flag_q;
        stat_word[SR_TXEMPTY] = tdre_q && !busy_x;
        stat_word[SR_SPIENS]  = en_q;
    end
    wire [31:0] rxd_word = {12'h000, 2'h0, rx_code_q, 8'h00, rx_q};
    wire [31:0] wps_word = {16'h0000, viol_src_q, 7'h00, viol_q};
    wire [31:0] rd_mux   = (addr == OFF_MODE)  ? mode_q :
                           (addr == OFF_RXD)   ? rxd_word :
                           (addr == OFF_STAT)  ? stat_word :
                           (addr == OFF_IMASK) ? imr_q :
                           (addr == OFF_CSC0)  ? csc0_q :
                           (addr == OFF_CSC1)  ? csc1_q :
                           (addr == OFF_WPM)   ? {31'h00000000, wp_on_q} :
                           (addr == OFF_WPS)   ? wps_word : 32'h00000000;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rd ? rd_mux : 32'h00000000;
    end
    assign rdata = rdata_q;

    // Pins released while disabled
    wire master_on = en_q && master;
    assign sck_out  = sif.sck_o;
    assign sck_oe   = master_on;
    assign mosi_out = sif.mosi_o;
    assign mosi_oe  = master_on;
    assign miso_out = sif.mosi_o;
    assign miso_oe  = en_q && !master && !nss_s;
    assign cs_out   = cs_q;
    assign cs_oe    = {2{master_on}};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_gap_entry;
        (st_q != ST_GAP) ##1 (st_q == ST_GAP);
    endsequence
    sequence s_both_cmd;
        wr_ctrl && wdata[CR_EN] && wdata[CR_DIS] && !wdata[CR_SOFT_RESET];
    endsequence

    a_enable_cmd: assert property (cmd_en && !cmd_dis && !cmd_rst && !fault |=> en_q)
        else $error("enable command did not enable");
    a_no_new_start: assert property (dis_pend_q |-> !load_m)
        else $error("transfer started while disable pending");
    a_dis_wins: assert property (s_both_cmd and (!busy_x && !fault) |=> !en_q && !cs_oe[0])
        else $error("enable and disable together left unit on");
    a_soft_reset: assert property (cmd_rst |=> !master && !en_q && cs_q == CS_NONE)
        else $error("soft reset did not return to slave");
    a_wp_block: assert property (wr_mode && wp_on_q |=> $stable(mode_q))
        else $error("protected mode register changed");
    a_wait_read: assert property (load_m |-> !(mode_q[MR_WAIT_READ_BEFORE_SEND] && rdrf_q))
        else $error("start while receive data unread");
    a_gap_min: assert property (s_gap_entry |-> (cs_q == CS_NONE) [*6])
        else $error("select gap shorter than six clocks");
    a_rx_upper: assert property (rd_rxd |=> rdata[31:18] == 14'h0000 && rdata[15:8] == 8'h00)
        else $error("unused receive bits not zero");
    a_rx_code: assert property (done && !master |=> rx_code_q == 2'h0)
        else $error("slave receive code not zero");
    a_final_close: assert property (st_q == ST_SHIFT && done && (last_pend_q || sh_last_q)
                                    |=> cs_q == CS_NONE)
        else $error("final transfer did not release select");
    a_hold_keep: assert property (st_q == ST_SHIFT && done && !end_req |=> $stable(cs_q))
        else $error("held select dropped");
    a_fault_off: assert property (fault |=> !en_q && mode_fault_flag_q ##1 !en_q)
        else $error("mode fault not handled");
    a_fixed_code: assert property (load_m && !var_sel && !dec && mode_q[MR_PCS_LO +: 2] == 2'h1
                                   && st_q == ST_IDLE |=> cs_q == 2'h1)
        else $error("fixed code 01 wrong lines");
    a_var_code: assert property (load_m && var_sel && !dec && !txd_code_q[0]
                                 && st_q == ST_IDLE |=> cs_q == 2'h2)
        else $error("variable code x0 wrong lines");
endmodule : spi_register_interface

// file: test/spi_slave_model.sv
`timescale 1ns/10ps
module spi_slave_model (
    input  wire logic       sck,  // Serial clock
    input  wire logic       mosi, // Data from master
    input  wire logic [1:0] cs_n, // Select lines
    output logic            miso  // Data to master
);
    logic [7:0] sr_q = 8'ha5;
    logic       in_q = 1'b0;
    // Mode 0: sample on rise, shift on fall; echo received byte next time
    always @(posedge sck)
        if (cs_n != 2'h3)
            in_q <= mosi;
    always @(negedge sck)
        if (cs_n != 2'h3)
            sr_q <= {sr_q[6:0], in_q};
    // Released line shows inverse
    assign miso = (cs_n != 2'h3) ? sr_q[7] : ~sr_q[7];
endmodule : spi_slave_model

// file: test/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
    import spi_reg_pkg::*;
    logic mclk = 0, reset_n = 0, wr = 0, rd = 0, miso_in, sck_out, mosi_out, sck_oe;
    logic cs0_in = 1'b1;
    logic [8:0] addr = 9'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [1:0] cs_out;
    int miscompares = 0, checked = 0;
    always #50 mclk = ~mclk;
    spi_register_interface DUT (.mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
        .sck_in(1'b0), .sck_out, .sck_oe, .mosi_in(1'b0), .mosi_out, .mosi_oe(),
        .miso_in, .miso_out(), .miso_oe(), .cs0_in, .cs_out, .cs_oe());
    spi_slave_model slave (.sck(sck_out), .mosi(mosi_out), .cs_n(cs_out), .miso(miso_in));
    task complete_run;
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task wreg(input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [8:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    task wait_cs(input logic [1:0] c);
        for (int i = 0; i < 300 && cs_out !== c; i++)
            @(posedge mclk) #1;
    endtask : wait_cs
    task t_regs;
        rreg(OFF_MODE, v); `CHK("mode", MR_RESET, v)
        rreg(OFF_STAT, v); `CHK("stat", 32'h000000f0, v)
        wreg(9'h020, 32'hffffffff);
        rreg(9'h020, v); `CHK("rsvd", 32'h0, v)
        wreg(OFF_WPM, 32'h1);
        wreg(OFF_MODE, 32'h55);
        rreg(OFF_MODE, v); `CHK("wp", 32'h0, v)
        rreg(OFF_WPS, v); `CHK("wps", 32'h00000401, v)
        wreg(OFF_WPM, 32'h0);
        wreg(OFF_MODE, 32'hffffffff);
        rreg(OFF_MODE, v); `CHK("mode", MR_MASK, v)
        wreg(OFF_MODE, 32'h0);
    endtask : t_regs
    task t_enable;
        wreg(OFF_CTRL, 32'h0);
        rreg(OFF_STAT, v); `CHK("en0", 1'b0, v[SR_SPIENS])
        wreg(OFF_CTRL, 32'h3);
        rreg(OFF_STAT, v); `CHK("en3", 1'b0, v[SR_SPIENS])
        wreg(OFF_CTRL, 32'h1);
        rreg(OFF_STAT, v); `CHK("en1", 1'b1, v[SR_SPIENS])
    endtask : t_enable
    task t_xfer(input logic [31:0] m, input logic [31:0] rx, input logic [1:0] c);
        int n;
        wreg(OFF_MODE, m);
        wreg(OFF_CTRL, 32'h1);
        wreg(OFF_TXD, 32'h0000ff3c);
        wreg(OFF_TXD, 32'h0000005a);
        wait_cs(c);
        `CHK("cs", c, cs_out)
        wait_cs(2'h3);
        for (n = 0; n < 99 && cs_out === 2'h3; n++)
            @(posedge mclk) #1;
        `CHK("gap", 8, n)
        wait_cs(2'h3);
        rreg(OFF_RXD, v); `CHK("rx", rx, v)
    endtask : t_xfer
    task t_soft_reset;
        wreg(OFF_CTRL, 32'h80);
        rreg(OFF_MODE, v); `CHK("srst", 32'h0, v)
        rreg(OFF_STAT, v); `CHK("sen", 1'b0, v[SR_SPIENS])
    endtask : t_soft_reset
    task t_var;
        v = 32'h0;
        wreg(OFF_MODE, 32'h00000033);
        wreg(OFF_CSC0, 32'h00000008);
        wreg(OFF_CTRL, 32'h00000001);
        wreg(OFF_TXD, 32'h00020081);
        wait_cs(2'h2);
        `CHK("vcs", 2'h2, cs_out)
        for (int i = 0; i < 60 && !v[SR_RDRF]; i++)
            rreg(OFF_STAT, v);
        `CHK("hold", 2'h2, cs_out)
        wreg(OFF_TXD, 32'h01020042);
        repeat (20) @(posedge mclk);
        rreg(OFF_STAT, v); `CHK("wait_read_before_send", 1'b0, v[SR_TDRE])
        rreg(OFF_RXD, v); `CHK("vrx", 32'h0002005a, v)
        wait_cs(2'h3);
        `CHK("last", 2'h3, cs_out)
        rreg(OFF_RXD, v); `CHK("lrx", 32'h00020081, v)
    endtask : t_var
    task t_fault;
        wreg(OFF_MODE, 32'h00000001);
        cs0_in <= 1'b0;
        #1;
        `CHK("oe1", 1'b1, sck_oe)
        repeat (6) @(posedge mclk);
        cs0_in <= 1'b1;
        rreg(OFF_STAT, v); `CHK("mode_fault_flag", 1'b1, v[SR_MODE_FAULT_FLAG])
        `CHK("fen", 1'b0, v[SR_SPIENS])
        `CHK("oe0", 1'b0, sck_oe)
        rreg(OFF_STAT, v); `CHK("mclr", 1'b0, v[SR_MODE_FAULT_FLAG])
    endtask : t_fault
    initial
    begin
        #1000000;
        miscompares++;
        complete_run;
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs;
        t_enable;
        t_xfer(32'h08000011, 32'h0002003c, 2'h2);
        t_xfer(32'h08010091, 32'h0001005a, 2'h1);
        t_soft_reset;
        t_var;
        t_fault;
        complete_run;
    end
endmodule : testbench
